// [rtl/sssc_ctrl.v]
/*
  Sequencer start-up and shutdown controller: register file, step table,
  sequence engine, software reset and identification.
  Assumes a synchronous register port master and a 25 MHz sys_clk.
*/
`timescale 1ns/1ns
`include "sssc_defines.vh"

module sssc_ctrl #(
  // Arbitrary identification value
  parameter [15:0] DEVICE_ID = 16'h5ac3,
  parameter DELAY_UNIT_CYC = `SSSC_DELAY_UNIT_CYC,
  parameter STEPS = 64
) (
  // Clock and reset
  input wire sys_clk,
  input wire nrst,
  // Register port
  input wire [7:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [15:0] reg_rdata,
  // Block state
  output reg seq_running,
  output reg [15:0] dac_control,
  output reg offset_valid,
  output reg [15:0] step_bus_data,
  output reg [7:0] step_bus_addr,
  output reg step_bus_wr
);

  // ==========================================================
  // States
  localparam [1:0] ST_IDLE = 2'd0;
  localparam [1:0] ST_LOAD = 2'd1;
  localparam [1:0] ST_WAIT = 2'd2;
  localparam [1:0] ST_EXEC = 2'd3;

  // Step word: [31:24] target, [23:20] lsb, [19:16] width,
  // [14] end, [11:8] delay, [7:0] value
  reg [31:0] step_mem [0:STEPS-1];
  reg [15:0] seq0_r;
  reg [15:0] seq1_r;
  reg [15:0] seq2_r;
  reg [15:0] seq3_r;
  reg [1:0] state_r;
  reg [5:0] idx_r;
  reg [31:0] step_r;
  reg [19:0] wait_r;
  reg sw_rst_r;
  integer i;

  wire seq_enable = seq0_r[`SSSC_SEQ0_ENA_BIT];
  wire [5:0] seq_edit_index = seq0_r[5:0];
  wire [5:0] seq_first_index = seq3_r[5:0];
  wire seq_abort = seq3_r[`SSSC_SEQ3_ABORT_BIT];
  wire wr_seq3 = reg_wr && reg_addr == `SSSC_OFF_SEQ3;

  // Default step contents; calibration step at index 17
  function [31:0] dflt_step;
    input [5:0] idx;
    begin
      case (idx)
        6'd17: dflt_step = {8'h57, 4'h0, 4'h0, 2'b00, 2'b00, 4'hf, 8'h01};
        6'd24: dflt_step = {8'h21, 4'h0, 4'h0, 2'b01, 2'b00, 4'h0, 8'h00};
        6'd36: dflt_step = {8'h05, 4'h0, 4'h0, 2'b00, 2'b00, 4'hc, 8'h00};
        6'd37: dflt_step = {8'h05, 4'h0, 4'h0, 2'b00, 2'b00, 4'h9, 8'h00};
        6'd39: dflt_step = {8'h04, 4'h0, 4'h1, 2'b01, 2'b00, 4'h0, 8'h00};
        default: dflt_step = {8'hff, 4'h0, 4'h0, 2'b00, 2'b00, 4'h3, 8'h00};
      endcase
    end
  endfunction

  // Step delays set shutdown time
  // Delay cycles: 2^delay/16 units of 62.5 us, at least one cycle
  function [19:0] delay_cycles;
    input [3:0] d;
    begin
      delay_cycles = ((20'h0_0001 << d[3:0]) >> 4) * DELAY_UNIT_CYC[19:0];
      if (delay_cycles == 20'h0_0000) begin
        delay_cycles = 20'h0_0001;
      end
    end
  endfunction

  // ==========================================================
  // Step table
  // Defaults restored on reset
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      for (i = 0; i < STEPS; i = i + 1) begin
        step_mem[i] <= dflt_step(i[5:0]);
      end
    end else if (sw_rst_r) begin
      for (i = 0; i < STEPS; i = i + 1) begin
        step_mem[i] <= dflt_step(i[5:0]);
      end
    end else if (reg_wr && seq_enable && reg_addr == `SSSC_OFF_SEQ2) begin
      step_mem[seq_edit_index] <= {seq1_r[7:0], seq1_r[11:8], seq1_r[14:12], 1'b0,
                                   reg_wdata};
    end
  end

  // ==========================================================
  // Registers and sequence engine
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      seq0_r <= `SSSC_SEQ_RST;
      seq1_r <= `SSSC_SEQ_RST;
      seq2_r <= `SSSC_SEQ_RST;
      seq3_r <= `SSSC_SEQ_RST;
      dac_control <= `SSSC_DAC1_RST;
      reg_rdata <= 16'h0000;
      seq_running <= 1'b0;
      offset_valid <= 1'b0;
      state_r <= ST_IDLE;
      idx_r <= 6'd0;
      step_r <= 32'h0000_0000;
      wait_r <= 20'h0_0000;
      step_bus_data <= 16'h0000;
      step_bus_addr <= 8'h00;
      step_bus_wr <= 1'b0;
      sw_rst_r <= 1'b0;
    end else begin
      step_bus_wr <= 1'b0;
      sw_rst_r <= 1'b0;
      reg_rdata <= 16'h0000;
      if (reg_rd) begin
        case (reg_addr)
          `SSSC_OFF_RST_ID: reg_rdata <= DEVICE_ID;
          `SSSC_OFF_DAC1: reg_rdata <= dac_control;
          `SSSC_OFF_SEQ0: reg_rdata <= seq0_r;
          `SSSC_OFF_SEQ1: reg_rdata <= seq1_r;
          `SSSC_OFF_SEQ2: reg_rdata <= seq2_r;
          `SSSC_OFF_SEQ3: reg_rdata <= seq3_r;
          `SSSC_OFF_SEQ4: reg_rdata <= {15'h0000, seq_running};
          default: reg_rdata <= 16'h0000;
        endcase
      end
      if (sw_rst_r) begin
        seq0_r <= `SSSC_SEQ_RST;
        seq1_r <= `SSSC_SEQ_RST;
        seq2_r <= `SSSC_SEQ_RST;
        seq3_r <= `SSSC_SEQ_RST;
        dac_control <= `SSSC_DAC1_RST;
        seq_running <= 1'b0;
        offset_valid <= 1'b0;
        state_r <= ST_IDLE;
      end else begin
        if (reg_wr) begin
          case (reg_addr)
            `SSSC_OFF_RST_ID: sw_rst_r <= 1'b1;
            `SSSC_OFF_DAC1: dac_control <= reg_wdata;
            `SSSC_OFF_SEQ0: seq0_r <= reg_wdata;
            `SSSC_OFF_SEQ1: seq1_r <= reg_wdata;
            `SSSC_OFF_SEQ2: seq2_r <= reg_wdata;
            `SSSC_OFF_SEQ3: seq3_r <= {reg_wdata[15:9], 1'b0, reg_wdata[7:0]};
            default: seq_running <= seq_running;
          endcase
        end
        case (state_r)
          ST_IDLE: begin
            if (wr_seq3 && reg_wdata[`SSSC_SEQ3_LAUNCH_BIT] && !reg_wdata[9] && seq_enable) begin
              idx_r <= reg_wdata[5:0];
              seq_running <= 1'b1;
              state_r <= ST_LOAD;
            end
          end
          ST_LOAD: begin
            step_r <= step_mem[idx_r];
            wait_r <= delay_cycles(step_mem[idx_r][11:8]);
            state_r <= ST_WAIT;
          end
          ST_WAIT: begin
            if (wait_r == 20'h0_0001) begin
              state_r <= ST_EXEC;
            end else begin
              wait_r <= wait_r - 20'h0_0001;
            end
          end
          ST_EXEC: begin
            if (step_r[31:24] != `SSSC_DUMMY_TARGET) begin
              step_bus_addr <= step_r[31:24];
              step_bus_data <= {8'h00, step_r[7:0]} << step_r[23:20];
              step_bus_wr <= 1'b1;
            end
            if (step_r[31:24] == 8'h57) begin
              offset_valid <= 1'b1;
            end
            if (step_r[`SSSC_STEP_EOS_BIT] || idx_r == STEPS - 1) begin
              seq_running <= 1'b0;
              state_r <= ST_IDLE;
            end else begin
              idx_r <= idx_r + 6'd1;
              state_r <= ST_LOAD;
            end
          end
          default: state_r <= ST_IDLE;
        endcase
        // Abort stops at once
        if (state_r != ST_IDLE && wr_seq3 && reg_wdata[9]) begin
          seq_running <= 1'b0;
          state_r <= ST_IDLE;
        end
      end
    end
  end

endmodule

// [rtl/sssc_defines.vh]
/*
  Register offsets, field positions, reset values and timing counts for the
  sequencer start-up and shutdown controller.
  Assumes inclusion by its bare name from the design file.
*/
`ifndef SSSC_DEFINES_VH
`define SSSC_DEFINES_VH

// ==========================================================
// Register offsets (word index on the plain register port)
`define SSSC_OFF_RST_ID 8'h00
`define SSSC_OFF_DAC1 8'h21
`define SSSC_OFF_SEQ0 8'h6c
`define SSSC_OFF_SEQ1 8'h6d
`define SSSC_OFF_SEQ2 8'h6e
`define SSSC_OFF_SEQ3 8'h6f
`define SSSC_OFF_SEQ4 8'h70

// ==========================================================
// Field positions
`define SSSC_SEQ0_ENA_BIT 8
`define SSSC_SEQ3_ABORT_BIT 9
`define SSSC_SEQ3_LAUNCH_BIT 8
`define SSSC_SEQ4_RUN_BIT 0
`define SSSC_STEP_EOS_BIT 14

// ==========================================================
// Reset values
`define SSSC_DAC1_RST 16'h0008
`define SSSC_SEQ_RST 16'h0000
`define SSSC_DUMMY_TARGET 8'hff

// ==========================================================
// Timing
`define SSSC_CLK_HZ 25000000
`define SSSC_DELAY_UNIT_US 62.5
`define SSSC_DELAY_UNIT_CYC 1563
`define SSSC_FAST_START_MS 50
`define SSSC_SHUTDOWN_MS 350

`endif

// [tb/sssc_ctrl_props.sv]
/* Port checker for sssc_ctrl.
   Assumes binding onto every sssc_ctrl instance. */
`timescale 1ns/1ns
module sssc_ctrl_props #(
  parameter [15:0] DEVICE_ID = 16'h0000
) (
  // Clock and reset
  input wire sys_clk,
  input wire nrst,
  // Register port
  input wire [7:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [15:0] reg_rdata,
  // Block state
  input wire seq_running,
  input wire [15:0] dac_control,
  input wire offset_valid,
  input wire [15:0] step_bus_data,
  input wire [7:0] step_bus_addr,
  input wire step_bus_wr
);
  // ==========================================
  // Shadow of the sequencer enable
  reg ena_r;
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) ena_r <= 1'b0;
    else if (reg_wr && reg_addr == 8'h00) ena_r <= 1'b0;
    else if (reg_wr && reg_addr == 8'h6c) ena_r <= reg_wdata[8];
  end
  // ==========================================
  // Properties
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data not zero outside read");
  a_id_read: assert property ($past(reg_rd) && $past(reg_addr) == 8'h00 |->
    reg_rdata == DEVICE_ID) else $error("identification read wrong");
  a_dac_readback: assert property ($past(reg_rd) && $past(reg_addr) == 8'h21 |->
    reg_rdata == $past(dac_control)) else $error("converter control readback wrong");
  a_dac_write: assert property (reg_wr && reg_addr == 8'h21 |=>
    dac_control == $past(reg_wdata)) else $error("converter control not written");
  a_launch_run: assert property (reg_wr && reg_addr == 8'h6f && reg_wdata[9:8] == 2'b01
    && ena_r && !seq_running |=> seq_running) else $error("launch did not start");
  a_refused_launch: assert property (reg_wr && reg_addr == 8'h6f && !ena_r
    && !seq_running |=> !seq_running) else $error("disabled launch started");
  a_soft_reset: assert property (reg_wr && reg_addr == 8'h00 |-> ##2 !seq_running
    && !offset_valid && dac_control == 16'h0008) else $error("soft reset incomplete");
  a_step_single: assert property (step_bus_wr |=> !step_bus_wr)
    else $error("step write longer than one cycle");
  a_no_dummy_out: assert property (step_bus_wr |-> step_bus_addr != 8'hff)
    else $error("dummy step emitted");
  a_abort_stop: assert property (reg_wr && reg_addr == 8'h6f && reg_wdata[9:8] == 2'b10
    |-> ##[1:3] !seq_running) else $error("abort did not stop");
endmodule
bind sssc_ctrl sssc_ctrl_props #(.DEVICE_ID(DEVICE_ID)) u_props (.sys_clk(sys_clk),
  .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .seq_running(seq_running),
  .dac_control(dac_control), .offset_valid(offset_valid), .step_bus_data(step_bus_data),
  .step_bus_addr(step_bus_addr), .step_bus_wr(step_bus_wr));

// [tb/sssc_ctrl_tb.sv]
/* Self-checking bench for sssc_ctrl.
   Assumes the checker is bound from its own file. */
`timescale 1ns/1ns
module sssc_ctrl_tb;
  // Arbitrary identification value
  localparam [15:0] ID = 16'h3c5a;
  reg sys_clk = 1'b0;
  reg nrst = 1'b0;
  reg [7:0] reg_addr = 8'h00;
  reg [15:0] reg_wdata = 16'h0000;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  wire [15:0] reg_rdata, dac_control, step_bus_data;
  wire [7:0] step_bus_addr;
  wire seq_running, offset_valid, step_bus_wr;
  integer fail_count = 0;
  integer n_checks = 0;
  integer run_cyc = 0;
  integer cal_cnt = 0;
  integer i, j, t0, c0, td, dflt;
  reg [15:0] rnd = 16'h48aa;
  reg [15:0] q;
  sssc_ctrl #(.DEVICE_ID(ID), .DELAY_UNIT_CYC(4)) uut (.sys_clk(sys_clk), .nrst(nrst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .seq_running(seq_running), .dac_control(dac_control),
    .offset_valid(offset_valid), .step_bus_data(step_bus_data),
    .step_bus_addr(step_bus_addr), .step_bus_wr(step_bus_wr));
  always #20 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    if (seq_running === 1'b1) run_cyc <= run_cyc + 1;
    if (step_bus_wr === 1'b1 && step_bus_addr === 8'h57) cal_cnt <= cal_cnt + 1;
  end
  // ==========================================
  // Helpers
  function [15:0] xs(input [15:0] s);
    reg [15:0] t;
    begin
      t = s ^ (s << 7);
      t = t ^ (t >> 9);
      xs = t ^ (t << 8);
    end
  endfunction
  task chk(input [15:0] got, input [15:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task wr(input [7:0] a, input [15:0] d);
    begin
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, output [15:0] d);
    begin
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
    end
  endtask
  task launch(input [15:0] v);
    begin
      t0 = run_cyc;
      c0 = cal_cnt;
      wr(8'h6f, v);
      #1 chk({15'h0000, seq_running}, 16'h0001);
      q = 16'h0001;
      for (j = 0; j < 12000 && q[0] === 1'b1; j = j + 1) rd(8'h70, q);
      chk(q, 16'h0000);
      td = run_cyc - t0;
    end
  endtask
  task finish_test;
    begin
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  initial begin
    #(40 * 90000);
    fail_count = fail_count + 1;
    finish_test;
  end
  // ==========================================
  // Tests
  initial begin
    repeat (20) @(posedge sys_clk);
    nrst <= 1'b1;
    rd(8'h00, q);
    chk(q, ID);
    rd(8'h21, q);
    chk(q, 16'h0008);
    for (i = 0; i < 8; i = i + 1) begin
      rnd = xs(rnd);
      wr(8'h21, rnd);
      rd(8'h21, q);
      chk(q, rnd);
    end
    $display("test 1 done");
    wr(8'h6c, 16'h0100);
    launch(16'h0100);
    dflt = td;
    chk({15'h0000, offset_valid}, 16'h0001);
    chk({15'h0000, cal_cnt > c0}, 16'h0001);
    $display("test 2 done");
    // Fast start from standby after calibration
    wr(8'h6c, 16'h0111);
    wr(8'h6d, 16'h00ff);
    wr(8'h6e, 16'h0000);
    launch(16'h0100);
    wr(8'h21, 16'h0000);
    rd(8'h21, q);
    chk(q, 16'h0000);
    chk({15'h0000, cal_cnt == c0}, 16'h0001);
    chk({15'h0000, td < dflt}, 16'h0001);
    chk({15'h0000, offset_valid}, 16'h0001);
    // Clock kept running until flag clears
    launch(16'h0119);
    wr(8'h6f, 16'h0100);
    wr(8'h6f, 16'h0200);
    rd(8'h70, q);
    chk(q, 16'h0000);
    $display("test 3 done");
    rnd = xs(rnd);
    wr(8'h00, rnd);
    rd(8'h00, q);
    chk(q, ID);
    rd(8'h21, q);
    chk(q, 16'h0008);
    chk({15'h0000, offset_valid}, 16'h0000);
    wr(8'h6f, 16'h0100);
    #1 chk({15'h0000, seq_running}, 16'h0000);
    wr(8'h6c, 16'h0100);
    launch(16'h0100);
    chk({15'h0000, cal_cnt > c0}, 16'h0001);
    $display("test 4 done");
    finish_test;
  end
endmodule
